// ### hdl/ilc_top.v
// Summary of operation
// - Bits 5-4 set generated code length
// - Generation uses low bits, 5 to 8
// - Bits 3-2 activate length, reset five bits
// - Bits 1-0 deactivate length, reset six bits
// - Pattern bit 0 sent last
`timescale 1ns/1ps
`include "ilc_defines.vh"
module ilc_top (
  // Clock and reset
  input  wire        i_mclk,
  input  wire        i_rstn,
  // Wishbone slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [13:0] i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  // Code lengths to generator and detectors
  output wire [1:0]  o_gen_code_length_sel,
  output wire [1:0]  o_activate_code_length_sel,
  output wire [1:0]  o_deactivate_code_length_sel,
  output wire [7:0]  o_activate_code_mask,
  output wire [7:0]  o_deactivate_code_mask,
  output wire [3:0]  o_gen_len,
  // Serial generated code stream
  input  wire        i_gen_en,
  input  wire        i_bit_en,
  output reg         o_gen_bit
);
  // --------------------------------------------------------------------------
  // Local declarations
  // --------------------------------------------------------------------------
  // Stored register fields
  reg  [1:0] gen_len_ff;
  reg  [1:0] act_len_ff;
  reg  [1:0] deact_len_ff;
  reg  [7:0] gen_pat_ff;
  // Next values of the stored fields
  reg  [1:0] nxt_gen_len;
  reg  [1:0] nxt_act_len;
  reg  [1:0] nxt_deact_len;
  reg  [7:0] nxt_gen_pat;
  // Decoded masks and length, held in flip-flops
  reg  [7:0] gen_mask_ff;
  reg  [7:0] act_mask_ff;
  reg  [7:0] deact_mask_ff;
  reg  [3:0] gen_len_cnt_ff;
  // Decoder results for the next field values
  wire [7:0] nxt_gen_mask;
  wire [7:0] nxt_act_mask;
  wire [7:0] nxt_deact_mask;
  wire [3:0] nxt_gen_len_cnt;
  // Serial stream position and next bit
  reg  [2:0] bit_idx_ff;
  reg  [2:0] nxt_bit_idx;
  reg        nxt_gen_bit;
  wire [2:0] last_idx;
  // Bus decode
  wire [7:0] ctrl_rd;
  wire       req;
  wire       wr_en;
  wire       hit_ctrl;
  wire       hit_pat;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // Ack low is part of the take, so a held request is taken only once
  assign req      = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // The registers are one byte wide; only lane 0 may write them
  assign wr_en    = req & i_wb_we & i_wb_sel[0];
  // Full address compare: a partial decode would let stray writes land
  assign hit_ctrl = (i_wb_adr == `ILC_BADDR_LEN_CTRL);
  assign hit_pat  = (i_wb_adr == `ILC_BADDR_GEN_PAT);

  assign ctrl_rd = {2'h0, gen_len_ff, act_len_ff, deact_len_ff};

  // --------------------------------------------------------------------------
  // Register next values
  // --------------------------------------------------------------------------
  // A write lands at the edge that takes it, so the new fields already
  // stand when the master sees the ack
  always @* begin
    nxt_gen_len   = gen_len_ff;
    nxt_act_len   = act_len_ff;
    nxt_deact_len = deact_len_ff;
    nxt_gen_pat   = gen_pat_ff;
    if (wr_en) begin
      if (hit_ctrl) begin
        nxt_gen_len   = i_wb_dat[`ILC_GEN_LEN_HI:`ILC_GEN_LEN_LO];
        nxt_act_len   = i_wb_dat[`ILC_ACT_LEN_HI:`ILC_ACT_LEN_LO];
        nxt_deact_len = i_wb_dat[`ILC_DEACT_LEN_HI:`ILC_DEACT_LEN_LO];
      end else if (hit_pat) begin
        nxt_gen_pat   = i_wb_dat[`ILC_GEN_PAT_HI:`ILC_GEN_PAT_LO];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  // reset lengths
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      gen_len_ff   <= `ILC_GEN_LEN_RST;
      act_len_ff   <= `ILC_ACT_LEN_RST;
      deact_len_ff <= `ILC_DEACT_LEN_RST;
      gen_pat_ff   <= `ILC_GEN_PAT_RST;
    end else begin
      gen_len_ff   <= nxt_gen_len;
      act_len_ff   <= nxt_act_len;
      deact_len_ff <= nxt_deact_len;
      gen_pat_ff   <= nxt_gen_pat;
    end
  end

  // Field outputs come straight from storage
  assign o_gen_code_length_sel        = gen_len_ff;
  assign o_activate_code_length_sel   = act_len_ff;
  assign o_deactivate_code_length_sel = deact_len_ff;

  // --------------------------------------------------------------------------
  // Length decode
  // --------------------------------------------------------------------------
  // Decoding the next values lets masks and length sit in flip-flops,
  // yet change at the same edge as the fields they follow
  // low-order bit masks
  ilc_len_mask u_gen_mask (
    .i_sel  (nxt_gen_len),
    .o_mask (nxt_gen_mask),
    .o_len  (nxt_gen_len_cnt)
  );
  ilc_len_mask u_act_mask (
    .i_sel  (nxt_act_len),
    .o_mask (nxt_act_mask),
    .o_len  ()
  );
  ilc_len_mask u_deact_mask (
    .i_sel  (nxt_deact_len),
    .o_mask (nxt_deact_mask),
    .o_len  ()
  );

  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      gen_mask_ff    <= `ILC_GEN_MASK_RST;
      act_mask_ff    <= `ILC_ACT_MASK_RST;
      deact_mask_ff  <= `ILC_DEACT_MASK_RST;
      gen_len_cnt_ff <= `ILC_GEN_CNT_RST;
    end else begin
      gen_mask_ff    <= nxt_gen_mask;
      act_mask_ff    <= nxt_act_mask;
      deact_mask_ff  <= nxt_deact_mask;
      gen_len_cnt_ff <= nxt_gen_len_cnt;
    end
  end

  // Decoded outputs for the generator and both detectors
  assign o_activate_code_mask   = act_mask_ff;
  assign o_deactivate_code_mask = deact_mask_ff;
  assign o_gen_len              = gen_len_cnt_ff;

  // --------------------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------------------
  // Ack one cycle after the take; unmapped reads return zero and are
  // still acked, so a stray access cannot hang the master
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= req;
      // Read data is held until the next read, not cleared after the ack
      if (req && !i_wb_we) begin
        if (hit_ctrl) begin
          o_wb_dat <= {24'h0, ctrl_rd};
        end else if (hit_pat) begin
          o_wb_dat <= {24'h0, gen_pat_ff};
        end else begin
          o_wb_dat <= 32'h0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Serial generated code
  // --------------------------------------------------------------------------
  // Index of the top valid bit; 8 wraps to 0 in three bits, so the
  // subtraction lands on 7 for the full byte
  assign last_idx = gen_len_cnt_ff[2:0] - 3'h1;

  // bit zero sent last
  // Dropping the enable reloads the top bit, so a new length starts
  // cleanly; a change while running is only masked, not realigned
  always @* begin
    nxt_bit_idx = bit_idx_ff;
    nxt_gen_bit = o_gen_bit;
    if (!i_gen_en) begin
      nxt_bit_idx = last_idx;
      nxt_gen_bit = 1'b0;
    end else if (i_bit_en) begin
      nxt_gen_bit = gen_pat_ff[bit_idx_ff] & gen_mask_ff[bit_idx_ff];
      nxt_bit_idx = (bit_idx_ff == 3'h0) ? last_idx : bit_idx_ff - 3'h1;
    end
  end

  // The bit-rate enable is a one-cycle pulse from the generator's divider
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      bit_idx_ff <= `ILC_BIT_IDX_RST;
      o_gen_bit  <= 1'b0;
    end else begin
      bit_idx_ff <= nxt_bit_idx;
      o_gen_bit  <= nxt_gen_bit;
    end
  end
endmodule // ilc_top

// ### hdl/ilc_defines.vh
`ifndef ILC_DEFINES_VH
`define ILC_DEFINES_VH
// ----------------------------------------------------------------------------
// Register map (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------------
`define ILC_ADDR_W          12
`define ILC_OFS_LEN_CTRL    12'h7d5
`define ILC_IDX_LEN_CTRL    12'h7d5
`define ILC_BADDR_LEN_CTRL  14'h1f54
`define ILC_BADDR_GEN_PAT   14'h1f58
// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define ILC_GEN_LEN_HI      5
`define ILC_GEN_LEN_LO      4
`define ILC_ACT_LEN_HI      3
`define ILC_ACT_LEN_LO      2
`define ILC_DEACT_LEN_HI    1
`define ILC_DEACT_LEN_LO    0
`define ILC_GEN_LEN_RST     2'h0
`define ILC_ACT_LEN_RST     2'h0
`define ILC_DEACT_LEN_RST   2'h1
`define ILC_GEN_PAT_RST     8'h01
`define ILC_LEN_BASE        4'h5
`define ILC_GEN_PAT_HI      7
`define ILC_GEN_PAT_LO      0
`define ILC_GEN_MASK_RST    8'h1f
`define ILC_ACT_MASK_RST    8'h1f
`define ILC_DEACT_MASK_RST  8'h3f
`define ILC_GEN_CNT_RST     4'h5
`define ILC_BIT_IDX_RST     3'h0
`endif

// ### hdl/ilc_len_mask.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Length select to valid-bit mask and bit count
// ----------------------------------------------------------------------------
`include "ilc_defines.vh"
module ilc_len_mask (
  // Select
  input  wire [1:0] i_sel,
  // Results
  output wire [7:0] o_mask,
  output wire [3:0] o_len
);
  // 00..11 select 5..8 low-order bits
  assign o_len  = `ILC_LEN_BASE + {2'h0, i_sel};
  assign o_mask = (i_sel == 2'h0) ? 8'h1f :
                  (i_sel == 2'h1) ? 8'h3f :
                  (i_sel == 2'h2) ? 8'h7f : 8'hff;
endmodule // ilc_len_mask

// ### tb/ilc_checker.sv
`timescale 1ns/1ps
module ilc_checker (
  // Bus and clock
  input wire logic        i_mclk, i_rstn, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack,
  input wire logic [13:0] i_wb_adr,
  input wire logic [3:0]  i_wb_sel, o_gen_len,
  input wire logic [31:0] i_wb_dat, o_wb_dat,
  // Length fields
  input wire logic [1:0]  o_gen_code_length_sel, o_activate_code_length_sel,
  input wire logic [1:0]  o_deactivate_code_length_sel,
  input wire logic [7:0]  o_activate_code_mask, o_deactivate_code_mask
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  wire ctl = i_wb_adr == 14'h1f54;
  wire [5:0] fld = {o_gen_code_length_sel, o_activate_code_length_sel,
                    o_deactivate_code_length_sel};
  // Ack comes one cycle after the take and lasts one cycle
  property p_ack; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_wr; o_wb_ack && i_wb_we && ctl && i_wb_sel[0] |-> fld == i_wb_dat[5:0]; endproperty
  a_wr: assert property (p_wr) else $error("length write lost");
  property p_len; o_gen_len == 4'h5 + o_gen_code_length_sel; endproperty
  a_len: assert property (p_len) else $error("gen length wrong");
  property p_am; o_activate_code_mask == 8'hff >> (2'd3 - o_activate_code_length_sel); endproperty
  a_am: assert property (p_am) else $error("activate mask wrong");
  property p_dm; o_deactivate_code_mask == 8'hff >> (2'd3 - o_deactivate_code_length_sel);
  endproperty
  a_dm: assert property (p_dm) else $error("deactivate mask wrong");
  // Reserved bits and upper lanes must read zero
  property p_rd; o_wb_ack && !i_wb_we && ctl |-> o_wb_dat == {26'h0, fld}; endproperty
  a_rd: assert property (p_rd) else $error("control readback wrong");
endmodule // ilc_checker
bind ilc_top ilc_checker ilc_checker_i (.*);

// ### tb/ilc_top_tb.sv
`timescale 1ns/1ps
module ilc_top_tb;
  logic i_mclk = 0, i_rstn = 0, cyc = 0, stb = 0, we = 0, gen_en = 0, bit_en = 0;
  logic [13:0] adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] dat = 0, rd, m, p, v;
  wire  [31:0] o_wb_dat;
  wire         o_wb_ack, o_gen_bit;
  wire  [1:0]  gs, as, ds;
  wire  [7:0]  am, dm;
  wire  [3:0]  gl;
  integer      failures = 0, num_checks = 0, n, i, k, j;
  logic        exp_bit = 0;
  ilc_top ilc_top_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .o_gen_code_length_sel(gs), .o_activate_code_length_sel(as),
    .o_deactivate_code_length_sel(ds), .o_activate_code_mask(am),
    .o_deactivate_code_mask(dm), .o_gen_len(gl), .i_gen_en(gen_en), .i_bit_en(bit_en),
    .o_gen_bit(o_gen_bit));
  initial forever #50 i_mclk = ~i_mclk;
  task chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One classic cycle; any slave latency is accepted up to 20 clocks, then counted as a failure
  task wb(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge i_mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= s;
    n = 0;
    do @(posedge i_mclk); while (o_wb_ack !== 1'b1 && ++n < 20);
    if (n >= 20) failures++;
    rd = o_wb_dat;
    cyc <= 0; stb <= 0;
  endtask
  task final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000 failures++;
    final_report;
  end
  initial begin
    void'($urandom(32'he7a31cfa));
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1;
    wb(0, 14'h1f54, 0, 4'hf); chk(rd, 32'h1);
    chk(gl, 5); chk(am, 8'h1f); chk(dm, 8'h3f);
    wb(0, 14'h1f58, 0, 4'hf); chk(rd, 32'h1);
    // Every code in all fields, junk above; last write lacks lane 0
    for (i = 0; i < 5; i++) begin
      v = ($urandom & 32'hffffffc0) | (i % 4) * 21;
      wb(1, 14'h1f54, v, {3'h7, i < 4});
      if (i < 4) m = v & 32'h3f;
      wb(0, 14'h1f54, 0, 4'hf); chk(rd, m);
      chk(gl, 5 + m[5:4]);
      chk(am, 8'hff >> (3 - m[3:2]));
      chk(dm, 8'hff >> (3 - m[1:0]));
      chk({gs, as, ds}, m[5:0]);
    end
    wb(0, 14'h0100, 0, 4'hf); chk(rd, 0);
    // Every length streams its top valid bit first, bit 0 last; random gaps
    p = $urandom;
    wb(1, 14'h1f58, p, 4'h1);
    wb(0, 14'h1f58, 0, 4'hf); chk(rd, p & 32'hff);
    for (k = 0; k < 4; k++) begin
      @(posedge i_mclk);
      gen_en <= 0; bit_en <= 0;
      wb(1, 14'h1f54, k << 4, 4'h1);
      @(posedge i_mclk);
      gen_en <= 1; bit_en <= 1; j = 0; exp_bit = 0;
      for (i = 0; i < 4 * (5 + k); i++) begin
        @(posedge i_mclk);
        if (bit_en) begin
          exp_bit = p[4 + k - j % (5 + k)];
          j++;
        end
        bit_en <= 1'($urandom);
        #1 chk(o_gen_bit, exp_bit);
      end
    end
    final_report;
  end
endmodule // ilc_top_tb
